// [verilog/spims_regs.vh]
// Register map, field positions, reset values and timing constants of the serial port block.
//------------------------------------------------------------------------------
// Notes on behaviour
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
`ifndef SPIMS_REGS_VH
`define SPIMS_REGS_VH

// Register indices; the byte address on the bus is four times the index.
`define SPIMS_IDX_DATA    6'h3c
`define SPIMS_IDX_CFG     6'h3d
`define SPIMS_IDX_STS     6'h3e
`define SPIMS_IDX_MASK    6'h3f
`define SPIMS_IDX_PINUSE  6'h3a
`define SPIMS_IDX_GPIO    6'h3b

// Reset values.
`define SPIMS_RST_BYTE    8'h00
`define SPIMS_RST_IRQ     2'h0

// Configuration fields.
`define SPIMS_CFG_SWAP    7
`define SPIMS_CFG_LSB     6
`define SPIMS_CFG_ROLE_HI 5
`define SPIMS_CFG_ROLE_LO 4
`define SPIMS_CFG_CPOL    3
`define SPIMS_CFG_CPHA    2
`define SPIMS_CFG_DIV_HI  1
`define SPIMS_CFG_DIV_LO  0

// Role codes.
`define SPIMS_ROLE_OFF    2'h0
`define SPIMS_ROLE_MASTER 2'h1
`define SPIMS_ROLE_SLAVE  2'h2

// Interrupt status bits.
`define SPIMS_IRQ_RXA     0
`define SPIMS_IRQ_TXE     1

// Pin positions in the use and gpio registers.
`define SPIMS_PIN_SCLK    0
`define SPIMS_PIN_SSEL    1
`define SPIMS_PIN_MOUT    2
`define SPIMS_PIN_MIN     3

// Half period of the master shift clock in core clocks, minus one (divisors 6, 12, 48, 96).
`define SPIMS_HALF_DIV0   6'h02
`define SPIMS_HALF_DIV1   6'h05
`define SPIMS_HALF_DIV2   6'h17
`define SPIMS_HALF_DIV3   6'h2f

// Shift clock edges per byte, minus one.
`define SPIMS_LAST_EDGE   5'h0f

`endif

// [verilog/spims_top.v]
// Serial peripheral port, master or slave, with Avalon-MM register access and interrupt.
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "spims_regs.vh"

module spims_top (
  // Clock and reset
  input  wire        CLOCK_I,
  input  wire        RST_N_I,
  // Avalon-MM slave
  input  wire [7:0]  AVS_ADDRESS_I,
  input  wire        AVS_READ_I,
  input  wire        AVS_WRITE_I,
  input  wire [31:0] AVS_WRITEDATA_I,
  input  wire [3:0]  AVS_BYTEENABLE_I,
  output wire [31:0] AVS_READDATA_O,
  output wire        AVS_WAITREQUEST_O,
  // Interrupt
  output wire        IRQ_O,
  // Shift clock pin
  input  wire        SCLK_I,
  output wire        SCLK_O,
  output wire        SCLK_OE_O,
  // Slave select pin
  input  wire        SSEL_N_I,
  output wire        SSEL_N_O,
  output wire        SSEL_N_OE_O,
  // Master-out data line
  input  wire        MASTER_OUT_LINE_I,
  output wire        MASTER_OUT_LINE_O,
  output wire        MASTER_OUT_LINE_OE_O,
  // Master-in data line
  input  wire        MASTER_IN_LINE_I,
  output wire        MASTER_IN_LINE_O,
  output wire        MASTER_IN_LINE_OE_O
);

  //----------------------------------------------------------------------------
  // Registers
  //----------------------------------------------------------------------------
  reg  [7:0]  cfg_r;
  reg  [7:0]  tx_hold_r;
  reg         tx_full_r;
  reg  [7:0]  tx_sh_r;
  reg  [7:0]  rx_sh_r;
  reg  [7:0]  rx_buf_r;
  reg  [1:0]  sts_r;
  reg  [1:0]  mask_r;
  reg  [3:0]  pin_use_r;
  reg  [3:0]  gpio_out_r;
  reg  [3:0]  gpio_oe_r;
  reg         busy_r;
  reg  [4:0]  edge_cnt_r;
  reg  [5:0]  div_cnt_r;
  reg         sclk_ph_r;
  reg         sclk_prev_r;
  reg         ack_r;
  reg  [31:0] rdata_r;

  //----------------------------------------------------------------------------
  // Decode of configuration
  //----------------------------------------------------------------------------
  wire [1:0]  role     = cfg_r[`SPIMS_CFG_ROLE_HI:`SPIMS_CFG_ROLE_LO];
  wire        is_mst   = (role == `SPIMS_ROLE_MASTER);
  wire        is_slv   = (role == `SPIMS_ROLE_SLAVE);
  wire        swap     = cfg_r[`SPIMS_CFG_SWAP];
  wire        lsb1st   = cfg_r[`SPIMS_CFG_LSB];
  wire        cpol     = cfg_r[`SPIMS_CFG_CPOL];
  wire        cpha     = cfg_r[`SPIMS_CFG_CPHA];
  wire [1:0]  div_sel  = cfg_r[`SPIMS_CFG_DIV_HI:`SPIMS_CFG_DIV_LO];
  reg  [5:0]  half_div;

  always @* begin
    case (div_sel)
      2'h0:    half_div = `SPIMS_HALF_DIV0;
      2'h1:    half_div = `SPIMS_HALF_DIV1;
      2'h2:    half_div = `SPIMS_HALF_DIV2;
      default: half_div = `SPIMS_HALF_DIV3;
    endcase
  end

  //----------------------------------------------------------------------------
  // Serial data path
  //----------------------------------------------------------------------------
  // The block drives master-out as master and master-in as slave; swap reverses this.
  wire        drive_mout = is_mst ^ swap;
  wire        din        = drive_mout ? MASTER_IN_LINE_I : MASTER_OUT_LINE_I;
  wire        dout       = lsb1st ? tx_sh_r[0] : tx_sh_r[7];
  wire [7:0]  rx_next    = lsb1st ? {din, rx_sh_r[7:1]} : {rx_sh_r[6:0], din};
  wire [7:0]  tx_next    = lsb1st ? {1'b0, tx_sh_r[7:1]} : {tx_sh_r[6:0], 1'b0};

  // Even edge indices are leading edges; sampling follows the phase bit.
  wire        samp_edge  = (edge_cnt_r[0] == cpha);
  wire        skip_shift = cpha && (edge_cnt_r == 5'h00);
  wire        last_edge  = (edge_cnt_r == `SPIMS_LAST_EDGE);

  wire        slv_sel    = is_slv && !SSEL_N_I;
  wire        mst_start  = is_mst && !busy_r && tx_full_r;
  wire        slv_start  = slv_sel && !busy_r;
  wire        start      = mst_start || slv_start;
  wire        mst_edge   = is_mst && busy_r && (div_cnt_r == 6'h00);
  wire        slv_edge   = slv_sel && busy_r && (SCLK_I != sclk_prev_r);
  wire        shift_ev   = mst_edge || slv_edge;
  wire        abort      = busy_r && !(is_mst || slv_sel);

  wire        ev_rxa     = shift_ev && last_edge;
  wire        ev_txe     = start && tx_full_r;

  //----------------------------------------------------------------------------
  // Avalon-MM access
  //----------------------------------------------------------------------------
  wire        req      = AVS_READ_I || AVS_WRITE_I;
  wire [5:0]  idx      = AVS_ADDRESS_I[7:2];
  wire        wr_do    = AVS_WRITE_I && ack_r && AVS_BYTEENABLE_I[0];
  wire [7:0]  wbyte    = AVS_WRITEDATA_I[7:0];
  reg  [7:0]  rd_mux;

  assign AVS_WAITREQUEST_O = req && !ack_r;
  assign AVS_READDATA_O    = rdata_r;

  always @* begin
    case (idx)
      `SPIMS_IDX_DATA:   rd_mux = rx_buf_r;
      `SPIMS_IDX_CFG:    rd_mux = cfg_r;
      `SPIMS_IDX_STS:    rd_mux = {SSEL_N_I, SCLK_I, MASTER_IN_LINE_I, MASTER_OUT_LINE_I,
                                   tx_full_r, busy_r, sts_r};
      `SPIMS_IDX_MASK:   rd_mux = {6'h00, mask_r};
      `SPIMS_IDX_PINUSE: rd_mux = {4'h0, pin_use_r};
      `SPIMS_IDX_GPIO:   rd_mux = {gpio_oe_r, gpio_out_r};
      default:           rd_mux = 8'h00;
    endcase
  end

  always @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r   <= req && !ack_r;
      rdata_r <= (AVS_READ_I && !ack_r) ? {24'h000000, rd_mux} : 32'h0000_0000;
    end
  end

  //----------------------------------------------------------------------------
  // Software registers and interrupt status
  //----------------------------------------------------------------------------
  always @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      cfg_r      <= `SPIMS_RST_BYTE;
      mask_r     <= `SPIMS_RST_IRQ;
      sts_r      <= `SPIMS_RST_IRQ;
      pin_use_r  <= 4'h0;
      gpio_out_r <= 4'h0;
      gpio_oe_r  <= 4'h0;
    end else begin
      if (wr_do && idx == `SPIMS_IDX_CFG)
        cfg_r <= wbyte;
      if (wr_do && idx == `SPIMS_IDX_MASK)
        mask_r <= wbyte[1:0];
      if (wr_do && idx == `SPIMS_IDX_PINUSE)
        pin_use_r <= wbyte[3:0];
      if (wr_do && idx == `SPIMS_IDX_GPIO) begin
        gpio_out_r <= wbyte[3:0];
        gpio_oe_r  <= wbyte[7:4];
      end
      // A new event in the clearing cycle keeps its bit set.
      sts_r <= (sts_r & ~((wr_do && idx == `SPIMS_IDX_STS) ? wbyte[1:0] : 2'h0))
             | {ev_txe, ev_rxa};
    end
  end

  assign IRQ_O = |(sts_r & mask_r);

  //----------------------------------------------------------------------------
  // Transfer engine
  //----------------------------------------------------------------------------
  always @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      tx_hold_r   <= `SPIMS_RST_BYTE;
      tx_full_r   <= 1'b0;
      tx_sh_r     <= `SPIMS_RST_BYTE;
      rx_sh_r     <= `SPIMS_RST_BYTE;
      rx_buf_r    <= `SPIMS_RST_BYTE;
      busy_r      <= 1'b0;
      edge_cnt_r  <= 5'h00;
      div_cnt_r   <= 6'h00;
      sclk_ph_r   <= 1'b0;
      sclk_prev_r <= 1'b0;
    end else begin
      sclk_prev_r <= SCLK_I;
      if (abort || role == `SPIMS_ROLE_OFF) begin
        busy_r     <= 1'b0;
        edge_cnt_r <= 5'h00;
        sclk_ph_r  <= 1'b0;
      end else if (start) begin
        // The holding byte moves to the shifter; in slave mode an empty holder repeats its last byte.
        tx_sh_r    <= tx_hold_r;
        tx_full_r  <= 1'b0;
        busy_r     <= 1'b1;
        edge_cnt_r <= 5'h00;
        div_cnt_r  <= half_div;
        sclk_ph_r  <= 1'b0;
      end else if (shift_ev) begin
        div_cnt_r  <= half_div;
        sclk_ph_r  <= !sclk_ph_r;
        edge_cnt_r <= edge_cnt_r + 5'h01;
        if (samp_edge)
          rx_sh_r <= rx_next;
        else if (!skip_shift)
          tx_sh_r <= tx_next;
        if (last_edge) begin
          busy_r   <= 1'b0;
          rx_buf_r <= samp_edge ? rx_next : rx_sh_r;
        end
      end else if (is_mst && busy_r) begin
        div_cnt_r <= div_cnt_r - 6'h01;
      end
      if (wr_do && idx == `SPIMS_IDX_DATA) begin
        tx_hold_r <= wbyte;
        tx_full_r <= 1'b1;
      end
    end
  end

  //----------------------------------------------------------------------------
  // Pin steering
  //----------------------------------------------------------------------------
  wire        active   = is_mst || is_slv;
  wire        own_sclk = active && pin_use_r[`SPIMS_PIN_SCLK];
  wire        own_ssel = is_mst && pin_use_r[`SPIMS_PIN_SSEL];
  wire        own_mout = active && pin_use_r[`SPIMS_PIN_MOUT];
  wire        own_min  = active && pin_use_r[`SPIMS_PIN_MIN];
  wire        drv_data = is_mst || slv_sel;

  assign SCLK_O      = own_sclk ? (cpol ^ sclk_ph_r) : gpio_out_r[`SPIMS_PIN_SCLK];
  assign SCLK_OE_O   = own_sclk ? is_mst : gpio_oe_r[`SPIMS_PIN_SCLK];
  assign SSEL_N_O    = own_ssel ? !busy_r : gpio_out_r[`SPIMS_PIN_SSEL];
  // Direction of the select pin always stays with firmware.
  assign SSEL_N_OE_O = gpio_oe_r[`SPIMS_PIN_SSEL];

  assign MASTER_OUT_LINE_O    = own_mout ? dout : gpio_out_r[`SPIMS_PIN_MOUT];
  assign MASTER_OUT_LINE_OE_O = own_mout ? (drive_mout && drv_data) : gpio_oe_r[`SPIMS_PIN_MOUT];
  assign MASTER_IN_LINE_O     = own_min ? dout : gpio_out_r[`SPIMS_PIN_MIN];
  assign MASTER_IN_LINE_OE_O  = own_min ? (!drive_mout && drv_data) : gpio_oe_r[`SPIMS_PIN_MIN];

endmodule // spims_top

`default_nettype wire

// [dv/spims_props.sv]
// Assertion checker for the serial port block.
`timescale 1ns/1ps
`default_nettype none
module spims_props (
  // Clock, reset and bus
  input wire logic        CLOCK_I,
  input wire logic        RST_N_I,
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic        AVS_WAITREQUEST_O,
  // Pins
  input wire logic        SCLK_O,
  input wire logic        SCLK_OE_O,
  input wire logic        SSEL_N_O,
  input wire logic        MASTER_OUT_LINE_O,
  input wire logic        MASTER_OUT_LINE_OE_O,
  input wire logic        MASTER_IN_LINE_OE_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  logic [4:0] edges_r;
  logic       sclk_r;
  logic       ssel_r;
  // Counts shift clock edges while select was low in the cycle before.
  always @(posedge CLOCK_I) begin
    sclk_r  <= SCLK_O;
    ssel_r  <= SSEL_N_O;
    edges_r <= (ssel_r || !RST_N_I) ? 5'h00 : edges_r + {4'h0, SCLK_O != sclk_r};
  end
  property p_wait_one; (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O; endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait longer than one cycle");
  property p_rdata; AVS_READ_I && !AVS_WAITREQUEST_O |-> AVS_READDATA_O[31:8] == 24'h0 ##1 AVS_READDATA_O == 32'h0; endproperty
  a_rdata: assert property (p_rdata) else $error("read data not framed");
  property p_idle; SCLK_OE_O && SSEL_N_O && $past(SSEL_N_O) && !$past(AVS_WRITE_I) |-> $stable(SCLK_O); endproperty
  a_idle: assert property (p_idle) else $error("shift clock moved while idle");
  property p_half_min; SCLK_OE_O && !SSEL_N_O && $changed(SCLK_O) |=> $stable(SCLK_O) [*2]; endproperty
  a_half_min: assert property (p_half_min) else $error("shift clock half period too short");
  property p_half_max; SCLK_OE_O && !SSEL_N_O |-> ##[0:48] ($changed(SCLK_O) || SSEL_N_O); endproperty
  a_half_max: assert property (p_half_max) else $error("shift clock half period too long");
  property p_edges; SCLK_OE_O && !ssel_r && SSEL_N_O |-> edges_r + {4'h0, SCLK_O != sclk_r} == 5'h10; endproperty
  a_edges: assert property (p_edges) else $error("byte without sixteen clock edges");
  property p_data; SCLK_OE_O && MASTER_OUT_LINE_OE_O && !SSEL_N_O && !$past(SSEL_N_O)
    && $changed(MASTER_OUT_LINE_O) |-> $changed(SCLK_O); endproperty
  a_data: assert property (p_data) else $error("data moved between clock edges");
  property p_one_drv; SCLK_OE_O && !SSEL_N_O |-> MASTER_OUT_LINE_OE_O != MASTER_IN_LINE_OE_O; endproperty
  a_one_drv: assert property (p_one_drv) else $error("data line drive not exclusive");
endmodule // spims_props
bind spims_top spims_props spims_props_inst (.CLOCK_I(CLOCK_I), .RST_N_I(RST_N_I), .AVS_READ_I(AVS_READ_I),
  .AVS_WRITE_I(AVS_WRITE_I), .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .SCLK_O(SCLK_O), .SCLK_OE_O(SCLK_OE_O), .SSEL_N_O(SSEL_N_O), .MASTER_OUT_LINE_O(MASTER_OUT_LINE_O),
  .MASTER_OUT_LINE_OE_O(MASTER_OUT_LINE_OE_O), .MASTER_IN_LINE_OE_O(MASTER_IN_LINE_OE_O));
`default_nettype wire

// [dv/spims_peer.sv]
// Behavioural model of the far-side serial device.
`timescale 1ns/1ps
`default_nettype none
module spims_peer (
  // Clock, reset and mode
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       cpha_i,
  input  wire logic       lsb_i,
  // Serial lines and bytes
  input  wire logic       sclk_i,
  input  wire logic       ssel_n_i,
  input  wire logic       si_i,
  output logic            so_o,
  input  wire logic [7:0] tx_i,
  output logic [7:0]      rx_o
);
  logic [4:0] edge_r;
  logic [4:0] half;
  logic [2:0] idx;
  logic       sclk_r;
  logic       ssel_r;
  logic       so_r;
  assign half = edge_r - {4'h0, cpha_i};
  assign idx  = lsb_i ? half[3:1] : 3'h7 - half[3:1];
  // A released line toggles every cycle, so a stale bit is never taken for data.
  assign so_o = ssel_n_i ? ~so_r : tx_i[idx];
  always @(posedge clk_i) begin
    sclk_r <= sclk_i;
    so_r   <= rst_n_i ? so_o : 1'b0;
    ssel_r <= rst_n_i ? ssel_n_i : 1'b1;
    // The closing edge of a byte is seen one cycle late, when select may already have risen.
    if (!rst_n_i || (ssel_n_i && ssel_r)) begin
      edge_r <= 5'h00;
    end else if (sclk_i != sclk_r) begin
      edge_r <= edge_r + 5'h01;
      if (edge_r[0] == cpha_i) rx_o[idx] <= si_i;
    end
  end
endmodule // spims_peer
`default_nettype wire

// [dv/spims_tb.sv]
// Self-checking testbench of the serial port block.
`timescale 1ns/1ps
`default_nettype none
`include "spims_regs.vh"
module testbench;
  logic        CLOCK_I = 1'b0;
  logic        RST_N_I = 1'b0;
  logic        AVS_READ_I = 1'b0;
  logic        AVS_WRITE_I = 1'b0;
  logic [7:0]  AVS_ADDRESS_I = 8'h00;
  logic [31:0] AVS_WRITEDATA_I = 32'h0;
  logic [3:0]  AVS_BYTEENABLE_I = 4'hf;
  logic        tb_sclk = 1'b0;
  logic        tb_ssel_n = 1'b1;
  logic        cpha = 1'b0;
  logic        lsb = 1'b0;
  logic [7:0]  peer_tx = 8'h00;
  wire  [7:0]  peer_rx;
  wire  [31:0] AVS_READDATA_O;
  wire         AVS_WAITREQUEST_O, IRQ_O, SCLK_I, SCLK_O, SCLK_OE_O, SSEL_N_I, SSEL_N_O, SSEL_N_OE_O, peer_so;
  wire         MASTER_OUT_LINE_I, MASTER_OUT_LINE_O, MASTER_OUT_LINE_OE_O;
  wire         MASTER_IN_LINE_I, MASTER_IN_LINE_O, MASTER_IN_LINE_OE_O;
  int          errors = 0;
  int          samples_checked = 0;
  // Each two-way pin takes the design's level while enabled, else the far side's.
  assign SCLK_I = SCLK_OE_O ? SCLK_O : tb_sclk;
  assign SSEL_N_I = SSEL_N_OE_O ? SSEL_N_O : tb_ssel_n;
  assign MASTER_OUT_LINE_I = MASTER_OUT_LINE_OE_O ? MASTER_OUT_LINE_O : peer_so;
  assign MASTER_IN_LINE_I = MASTER_IN_LINE_OE_O ? MASTER_IN_LINE_O : peer_so;
  always #12.5 CLOCK_I = ~CLOCK_I;
  spims_top spims_top_inst (.*);
  spims_peer spims_peer_inst (.clk_i(CLOCK_I), .rst_n_i(RST_N_I), .cpha_i(cpha), .lsb_i(lsb), .sclk_i(SCLK_I),
    .ssel_n_i(SSEL_N_I), .si_i(MASTER_IN_LINE_OE_O ? MASTER_IN_LINE_O : MASTER_OUT_LINE_O), .so_o(peer_so),
    .tx_i(peer_tx), .rx_o(peer_rx));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge CLOCK_I);
    AVS_ADDRESS_I <= {idx, 2'b00};
    AVS_WRITEDATA_I <= {24'h0, wd};
    AVS_WRITE_I <= wr;
    AVS_READ_I <= !wr;
    do begin
      @(posedge CLOCK_I);
      n++;
    end while (AVS_WAITREQUEST_O !== 1'b0 && n < 16);
    if (n >= 16) errors++;
    rd = AVS_READDATA_O[7:0];
    AVS_WRITE_I <= 1'b0;
    AVS_READ_I <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    logic [7:0] d;
    bus(1'b1, idx, wd, d);
  endtask
  task automatic rdc(input logic [5:0] idx, input logic [7:0] msk, input logic [7:0] exp);
    logic [7:0] d;
    bus(1'b0, idx, 8'h00, d);
    chk(d & msk, exp);
  endtask
  task automatic wait_rx;
    logic [7:0] d;
    d = 8'h00;
    repeat (400) if (d[0] !== 1'b1) bus(1'b0, `SPIMS_IDX_STS, 8'h00, d);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge CLOCK_I);
    errors++;
    report_and_stop;
  end
  initial begin
    logic [7:0] b;
    repeat (2) @(posedge CLOCK_I);
    RST_N_I <= 1'b1;
    rdc(`SPIMS_IDX_DATA, 8'hff, 8'h00);
    rdc(`SPIMS_IDX_CFG, 8'hff, 8'h00);
    rdc(6'h10, 8'hff, 8'h00);
    wr(`SPIMS_IDX_PINUSE, 8'h0f);
    wr(`SPIMS_IDX_GPIO, 8'h22);
    wr(`SPIMS_IDX_MASK, 8'h01);
    for (int i = 0; i < 5; i++) begin
      b = 8'h5a ^ i[7:0];
      cpha <= i[0];
      lsb <= i[1];
      peer_tx <= ~b;
      wr(`SPIMS_IDX_CFG, {i == 4, i[1], 2'h1, i[1] ^ i[0], i[0], i[1:0]});
      wr(`SPIMS_IDX_STS, 8'h03);
      chk({7'h0, SCLK_I}, {7'h0, i[1] ^ i[0]});
      wr(`SPIMS_IDX_DATA, b);
      wait_rx;
      rdc(`SPIMS_IDX_DATA, 8'hff, ~b);
      chk(peer_rx, b);
      chk({7'h0, IRQ_O}, 8'h01);
      rdc(`SPIMS_IDX_STS, 8'h03, 8'h03);
      wr(`SPIMS_IDX_STS, 8'h01);
      rdc(`SPIMS_IDX_STS, 8'h03, 8'h02);
      chk({7'h0, IRQ_O}, 8'h00);
    end
    wr(`SPIMS_IDX_GPIO, 8'h00);
    wr(`SPIMS_IDX_MASK, 8'h00);
    wr(`SPIMS_IDX_CFG, 8'h20);
    peer_tx <= 8'hc3;
    wr(`SPIMS_IDX_DATA, 8'h96);
    chk({7'h0, SCLK_OE_O}, 8'h00);
    @(posedge CLOCK_I);
    tb_ssel_n <= 1'b0;
    repeat (16) begin
      repeat (4) @(posedge CLOCK_I);
      tb_sclk <= ~tb_sclk;
    end
    repeat (4) @(posedge CLOCK_I);
    tb_ssel_n <= 1'b1;
    rdc(`SPIMS_IDX_DATA, 8'hff, 8'hc3);
    chk(peer_rx, 8'h96);
    chk({7'h0, IRQ_O}, 8'h00);
    wr(`SPIMS_IDX_MASK, 8'h01);
    rdc(`SPIMS_IDX_STS, 8'h01, 8'h01);
    chk({7'h0, IRQ_O}, 8'h01);
    wr(`SPIMS_IDX_CFG, 8'h00);
    wr(`SPIMS_IDX_GPIO, 8'h44);
    rdc(`SPIMS_IDX_GPIO, 8'hff, 8'h44);
    chk({6'h0, MASTER_OUT_LINE_OE_O, MASTER_OUT_LINE_O}, 8'h03);
    chk({7'h0, SSEL_N_OE_O}, 8'h00);
    report_and_stop;
  end
endmodule // testbench
`default_nettype wire
